// file: core/lrc_bus_seq.sv
// Bus sequencer for locked read-modify-write and breakpoint acknowledge reads.
// Assumes the core gives one request at a time and waits for done; bus pins
// are asynchronous and pass two flops before use. Each half-clock bus state
// is one clock of this logic.
`timescale 1ns/10ps
module lrc_bus_seq
  import lrc_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 32,
  parameter int IDLE_CYC = LRC_IDLE_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Core request: locked read-modify-write
  input wire logic rmw_start,
  input wire logic [ADDR_W-1:0] rmw_addr,
  input wire logic [3:0] rmw_fc,
  input wire logic [1:0] rmw_width,
  input wire logic [1:0] rmw_reads,
  input wire logic [1:0] rmw_writes,
  input wire logic [DATA_W-1:0] rmw_wdata,
  input wire logic rmw_addr_step,
  // Core request: software breakpoint
  input wire logic sw_breakpoint_request_n_start,
  input wire logic [2:0] sw_breakpoint_request_n_num,
  input wire logic port_8bit,
  input wire logic breakpoint_request_n_bg_mode,
  input wire logic pipe_flush,
  // Core answer
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic rd_valid,
  output lrc_bk_result_e breakpoint_request_n_result,
  output logic breakpoint_request_n_pending,
  // External bus outputs
  output logic [ADDR_W-1:0] address,
  output logic [3:0] function_code,
  output logic [1:0] transfer_width,
  output logic read_not_write,
  output logic address_strobe_n,
  output logic data_strobe_n,
  output logic locked_cycle_n,
  output logic bus_grant_out_n,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n,
  // External bus inputs
  input wire logic [1:0] data_ack_width_n,
  input wire logic bus_error_n,
  input wire logic bus_request_in_n,
  input wire logic breakpoint_request_n,
  input wire logic [DATA_W-1:0] data_in
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [4:0] ctl_sync;
  logic [DATA_W-1:0] data_sync;
  logic ack_seen;
  logic bus_error_n_seen;
  logic breq_seen;
  logic breakpoint_request_n_pin;

  lrc_sync #(.WIDTH(5), .RESET_VAL(5'h1f)) u_ctl_sync (
    .clock(clock),
    .rst(rst),
    .async_in({data_ack_width_n, bus_error_n, bus_request_in_n, breakpoint_request_n}),
    .sync_out(ctl_sync)
  );

  lrc_sync #(.WIDTH(DATA_W), .RESET_VAL('0)) u_data_sync (
    .clock(clock),
    .rst(rst),
    .async_in(data_in),
    .sync_out(data_sync)
  );

  assign ack_seen = ~(&ctl_sync[4:3]);
  assign bus_error_n_seen = ~ctl_sync[2];
  assign breq_seen = ~ctl_sync[1];
  assign breakpoint_request_n_pin = ~ctl_sync[0];

  // ****************************************
  // Sequence bookkeeping
  // ****************************************
  lrc_state_e state_q;
  logic is_breakpoint_request_n_q;
  logic hw_breakpoint_request_n_q;
  logic writing_q;
  logic [1:0] reads_left_q;
  logic [1:0] writes_left_q;
  logic [7:0] gap_cnt_q;
  logic bus_error_n_q;
  logic breakpoint_request_n_latch_q;
  logic last_read;
  logic last_write;
  logic grab_breakpoint_request_n;

  assign last_read = !writing_q && reads_left_q == 2'h0;
  assign last_write = writing_q && writes_left_q == 2'h0;
  // Hardware breakpoint is taken only when idle and background mode is off
  assign grab_breakpoint_request_n = state_q == LRC_IDLE && breakpoint_request_n_latch_q && !breakpoint_request_n_bg_mode && !rmw_start && !sw_breakpoint_request_n_start;

  // Pin carried with data; a flush discards it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      breakpoint_request_n_latch_q <= 1'b0;
    end else if (breakpoint_request_n_pin) begin
      // A fresh sample wins over a clear in the same cycle, so no request is lost
      breakpoint_request_n_latch_q <= 1'b1;
    end else if (pipe_flush || grab_breakpoint_request_n) begin
      breakpoint_request_n_latch_q <= 1'b0;
    end
  end

  // ****************************************
  // State machine
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= LRC_IDLE;
      is_breakpoint_request_n_q <= 1'b0;
      hw_breakpoint_request_n_q <= 1'b0;
      writing_q <= 1'b0;
      reads_left_q <= 2'h0;
      writes_left_q <= 2'h0;
      gap_cnt_q <= 8'h0;
      bus_error_n_q <= 1'b0;
    end else begin
      case (state_q)
        LRC_IDLE: begin
          bus_error_n_q <= 1'b0;
          writing_q <= 1'b0;
          if (rmw_start) begin
            state_q <= LRC_S0;
            is_breakpoint_request_n_q <= 1'b0;
            hw_breakpoint_request_n_q <= 1'b0;
            reads_left_q <= rmw_reads;
            writes_left_q <= rmw_writes;
          end else if (sw_breakpoint_request_n_start || grab_breakpoint_request_n) begin
            state_q <= LRC_S0;
            is_breakpoint_request_n_q <= 1'b1;
            hw_breakpoint_request_n_q <= !sw_breakpoint_request_n_start;
            // An 8-bit port needs two byte reads for the opcode
            reads_left_q <= (sw_breakpoint_request_n_start && port_8bit) ? 2'h1 : 2'h0;
            writes_left_q <= 2'h0;
          end
        end
        LRC_S0: state_q <= LRC_S1;
        LRC_S1: state_q <= LRC_S2;
        LRC_S2: state_q <= (ack_seen || bus_error_n_seen) ? LRC_S3 : LRC_SW;
        LRC_SW: state_q <= (ack_seen || bus_error_n_seen) ? LRC_S3 : LRC_SW;
        LRC_S3: begin
          bus_error_n_q <= bus_error_n_q | bus_error_n_seen;
          state_q <= LRC_S4;
        end
        LRC_S4: state_q <= LRC_S5;
        LRC_S5: begin
          if (is_breakpoint_request_n_q && (bus_error_n_q || last_read)) begin
            state_q <= LRC_IDLE;
          end else if (!writing_q && !last_read) begin
            reads_left_q <= reads_left_q - 2'h1;
            state_q <= LRC_S0;
          end else if (!writing_q) begin
            gap_cnt_q <= 8'(IDLE_CYC);
            state_q <= LRC_GAP;
          end else if (!last_write) begin
            writes_left_q <= writes_left_q - 2'h1;
            state_q <= LRC_S0;
          end else begin
            state_q <= LRC_IDLE;
          end
        end
        LRC_GAP: begin
          if (gap_cnt_q != 8'h0) begin
            gap_cnt_q <= gap_cnt_q - 8'h1;
          end else if (writes_left_q == 2'h3) begin
            // Write count of all ones means no write is wanted
            state_q <= LRC_IDLE;
          end else begin
            writing_q <= 1'b1;
            state_q <= LRC_S0;
          end
        end
        default: state_q <= LRC_IDLE;
      endcase
    end
  end

  // ****************************************
  // Address, code, width and direction
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      address <= '0;
      function_code <= 4'h0;
      transfer_width <= 2'h0;
      read_not_write <= 1'b1;
    end else if (state_q == LRC_IDLE && rmw_start) begin
      address <= rmw_addr;
      function_code <= rmw_fc;
      transfer_width <= rmw_width;
      read_not_write <= 1'b1;
    end else if (state_q == LRC_IDLE && (sw_breakpoint_request_n_start || grab_breakpoint_request_n)) begin
      address <= '0;
      address[LRC_TYPE_LSB +: 4] <= LRC_CPU_TYPE_BREAKPOINT_REQUEST_N;
      address[LRC_NUM_LSB +: 3] <= sw_breakpoint_request_n_start ? sw_breakpoint_request_n_num : LRC_HW_BREAKPOINT_REQUEST_N_NUM;
      address[LRC_KIND_BIT] <= !sw_breakpoint_request_n_start;
      function_code <= LRC_FC_CPU_SPACE;
      transfer_width <= (sw_breakpoint_request_n_start && port_8bit) ? LRC_WIDTH_BYTE : LRC_WIDTH_WORD;
      read_not_write <= 1'b1;
    end else if (state_q == LRC_GAP && gap_cnt_q == 8'h0 && writes_left_q != 2'h3) begin
      read_not_write <= 1'b0;
      if (rmw_addr_step) begin
        address <= rmw_addr;
      end
    end else if (state_q == LRC_S5 && !is_breakpoint_request_n_q && !writing_q && !last_read) begin
      address <= address + ADDR_W'(1);
    end else if (state_q == LRC_S5 && writing_q && !last_write) begin
      address <= address + ADDR_W'(1);
    end else if (state_q == LRC_S5 && is_breakpoint_request_n_q && !bus_error_n_q && !last_read) begin
      address[0] <= 1'b1;
    end else if (state_q == LRC_IDLE) begin
      read_not_write <= 1'b1;
    end
  end

  // ****************************************
  // Strobes and lock
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      address_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
    end else begin
      // Strobe outputs are registered from state_q, so they follow the state one clock late
      address_strobe_n <= !(state_q == LRC_S0 || state_q == LRC_S2 || state_q == LRC_SW ||
                            state_q == LRC_S3 || state_q == LRC_S1);
      data_strobe_n <= writing_q ? !(state_q == LRC_S2 || state_q == LRC_SW || state_q == LRC_S3)
                                 : !(state_q == LRC_S0 || state_q == LRC_S1 || state_q == LRC_S2 ||
                                     state_q == LRC_SW || state_q == LRC_S3);
      if (state_q == LRC_S4) begin
        address_strobe_n <= 1'b1;
        data_strobe_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      locked_cycle_n <= 1'b1;
    end else if (state_q == LRC_IDLE) begin
      locked_cycle_n <= !rmw_start;
    end else if (state_q == LRC_S5 && !is_breakpoint_request_n_q && last_write) begin
      locked_cycle_n <= 1'b1;
    end else if (state_q == LRC_GAP && gap_cnt_q == 8'h0 && writes_left_q == 2'h3) begin
      locked_cycle_n <= 1'b1;
    end
  end

  // Grant only when no locked sequence is active
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_grant_out_n <= 1'b1;
    end else begin
      bus_grant_out_n <= !(breq_seen && state_q == LRC_IDLE && locked_cycle_n && !rmw_start);
    end
  end

  // ****************************************
  // Write data drive
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_out <= '0;
      data_oe_n <= 1'b1;
    end else begin
      if (writing_q && state_q == LRC_S1) begin
        data_out <= rmw_wdata;
        data_oe_n <= 1'b0;
      end else if (state_q == LRC_IDLE || (state_q == LRC_S5 && last_write)) begin
        data_oe_n <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read capture and results
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (state_q == LRC_S4 && !writing_q && !bus_error_n_q && !hw_breakpoint_request_n_q) begin
        rd_valid <= 1'b1;
        if (is_breakpoint_request_n_q && port_8bit) begin
          rdata <= {rdata[7:0], data_sync[DATA_W-1 -: 8]};
        end else begin
          rdata <= data_sync;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
      breakpoint_request_n_result <= LRC_BK_NONE;
      breakpoint_request_n_pending <= 1'b0;
    end else begin
      done <= 1'b0;
      breakpoint_request_n_pending <= breakpoint_request_n_latch_q;
      if (state_q == LRC_S5 && is_breakpoint_request_n_q && (bus_error_n_q || last_read)) begin
        done <= 1'b1;
        if (bus_error_n_q) begin
          breakpoint_request_n_result <= hw_breakpoint_request_n_q ? LRC_BK_HW_EXC : LRC_BK_ILLEGAL;
        end else begin
          breakpoint_request_n_result <= hw_breakpoint_request_n_q ? LRC_BK_NONE : LRC_BK_OPCODE;
        end
      end else if ((state_q == LRC_S5 && writing_q && last_write) ||
                   (state_q == LRC_GAP && gap_cnt_q == 8'h0 && writes_left_q == 2'h3)) begin
        done <= 1'b1;
        breakpoint_request_n_result <= LRC_BK_NONE;
      end
    end
  end

endmodule

// file: core/lrc_pkg.sv
// Constants for the locked read-modify-write and CPU-space bus sequencer.
// Assumes a single 100 MHz clock; every bus input is asynchronous to it.
package lrc_pkg;

  // ****************************************
  // Bus encodings
  // ****************************************
  localparam logic [3:0] LRC_FC_CPU_SPACE = 4'h7;
  localparam logic [3:0] LRC_CPU_TYPE_BREAKPOINT_REQUEST_N = 4'h0;
  localparam logic [1:0] LRC_WIDTH_BYTE = 2'h1;
  localparam logic [1:0] LRC_WIDTH_WORD = 2'h2;
  localparam logic [2:0] LRC_HW_BREAKPOINT_REQUEST_N_NUM = 3'h7;
  localparam int LRC_TYPE_LSB = 16;
  localparam int LRC_NUM_LSB = 2;
  localparam int LRC_KIND_BIT = 1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int LRC_CLK_NS = 10;
  localparam int LRC_IDLE_NS = 20;
  localparam int LRC_IDLE_CYC = (LRC_IDLE_NS + LRC_CLK_NS - 1) / LRC_CLK_NS;

  // ****************************************
  // Sequencer states (half-clock bus states)
  // ****************************************
  typedef enum logic [3:0] {
    LRC_IDLE, LRC_S0, LRC_S1, LRC_S2, LRC_S3, LRC_SW, LRC_S4, LRC_S5, LRC_GAP
  } lrc_state_e;

  // Outcome of a breakpoint acknowledge read
  typedef enum logic [1:0] {
    LRC_BK_NONE, LRC_BK_OPCODE, LRC_BK_ILLEGAL, LRC_BK_HW_EXC
  } lrc_bk_result_e;

endpackage

// file: core/lrc_sync.sv
// Two-flop synchroniser, one per bit.
// Assumes inputs come from pins outside the clock domain.
`timescale 1ns/10ps
module lrc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ****************************************
  // Per-bit two flop chain
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          meta_q[i] <= RESET_VAL[i];
          sync_out[i] <= RESET_VAL[i];
        end else begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

// file: dv/lrc_bus_seq_sva.sv
// Checker for the locked bus sequencer, watching the top module ports only.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/10ps
module lrc_bus_seq_sva
  import lrc_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bus outputs
  input wire logic [ADDR_W-1:0] address,
  input wire logic [3:0] function_code,
  input wire logic read_not_write,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic locked_cycle_n,
  input wire logic bus_grant_out_n,
  input wire logic data_oe_n,
  // Bus inputs
  input wire logic [1:0] data_ack_width_n,
  input wire logic bus_error_n
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_no_grant; !locked_cycle_n |-> bus_grant_out_n; endproperty
  a_no_grant: assert property (p_no_grant) else $error("grant while locked");
  property p_lock_hold; $fell(locked_cycle_n) |-> !locked_cycle_n [*8]; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped early");
  property p_read_start;
    $fell(locked_cycle_n) |-> read_not_write && address_strobe_n ##1 !address_strobe_n && !data_strobe_n;
  endproperty
  a_read_start: assert property (p_read_start) else $error("bad locked read start");
  // Acknowledge passes two flops, so a strobe cannot end the cycle after it
  property p_wait; !data_strobe_n && (&data_ack_width_n) && bus_error_n |=> !data_strobe_n; endproperty
  a_wait: assert property (p_wait) else $error("strobe ended without answer");
  property p_hold;
    !address_strobe_n ##1 !address_strobe_n |-> $stable(address) && $stable(function_code) && $stable(read_not_write);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved in cycle");
  property p_gap; $rose(address_strobe_n) |=> address_strobe_n && data_strobe_n; endproperty
  a_gap: assert property (p_gap) else $error("strobe right after end");
  property p_no_drive; !data_oe_n |-> !read_not_write; endproperty
  a_no_drive: assert property (p_no_drive) else $error("data driven in read");
  property p_write_seq;
    $fell(read_not_write) |-> address_strobe_n ##1 (!address_strobe_n && data_strobe_n && data_oe_n)
      ##1 (!data_oe_n && data_strobe_n) ##1 !data_strobe_n;
  endproperty
  a_write_seq: assert property (p_write_seq) else $error("bad write order");
  property p_cpu_space;
    !address_strobe_n && locked_cycle_n && function_code == LRC_FC_CPU_SPACE
      |-> address[19:16] == LRC_CPU_TYPE_BREAKPOINT_REQUEST_N && read_not_write;
  endproperty
  a_cpu_space: assert property (p_cpu_space) else $error("bad space type");
  property p_reset_idle;
    $fell(rst) |-> address_strobe_n && data_strobe_n && locked_cycle_n && data_oe_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
endmodule

bind lrc_bus_seq lrc_bus_seq_sva #(.ADDR_W(ADDR_W)) chk_u (.clock, .rst, .address, .function_code,
  .read_not_write, .address_strobe_n, .data_strobe_n, .locked_cycle_n, .bus_grant_out_n, .data_oe_n,
  .data_ack_width_n, .bus_error_n);

// file: dv/lrc_bus_seq_test.sv
// Bench for the locked read-modify-write and breakpoint sequencer.
// Assumes the slave model on the bus pins and the checker bound to the sequencer.
`timescale 1ns/10ps
module lrc_bus_seq_test;
  import lrc_pkg::*;
  logic clock, rst, rmw_start, rmw_addr_step, sw_breakpoint_request_n_start, port_8bit, breakpoint_request_n_bg_mode, pipe_flush;
  logic [31:0] rmw_addr, address, cap_addr;
  logic [5:0] cap_code;
  logic [3:0] rmw_fc, function_code, wait_cyc;
  logic [1:0] rmw_width, rmw_reads, rmw_writes, transfer_width, data_ack_width_n;
  logic [15:0] rmw_wdata, rdata, data_out, data_in, rd_word, wr_word;
  logic [2:0] sw_breakpoint_request_n_num;
  logic done, rd_valid, breakpoint_request_n_pending, read_not_write, address_strobe_n, data_strobe_n, locked_cycle_n;
  logic bus_grant_out_n, data_oe_n, bus_error_n, bus_request_in_n, breakpoint_request_n, use_err;
  lrc_bk_result_e breakpoint_request_n_result;
  int n_fail, n_tests, n_as, n_rd, i;

  lrc_bus_seq dut_u (.clock, .rst, .rmw_start, .rmw_addr, .rmw_fc, .rmw_width, .rmw_reads, .rmw_writes,
    .rmw_wdata, .rmw_addr_step, .sw_breakpoint_request_n_start, .sw_breakpoint_request_n_num, .port_8bit, .breakpoint_request_n_bg_mode, .pipe_flush,
    .done, .rdata, .rd_valid, .breakpoint_request_n_result, .breakpoint_request_n_pending, .address, .function_code, .transfer_width,
    .read_not_write, .address_strobe_n, .data_strobe_n, .locked_cycle_n, .bus_grant_out_n, .data_out,
    .data_oe_n, .data_ack_width_n, .bus_error_n, .bus_request_in_n, .breakpoint_request_n, .data_in);
  lrc_slave_model slave_u (.clock, .rst, .read_not_write, .address_strobe_n, .data_strobe_n, .data_out,
    .wait_cyc, .use_err, .port8(port_8bit), .rd_word, .data_ack_width_n, .bus_error_n, .data_in, .wr_word);

  always #5 clock = !clock;
  always @(negedge address_strobe_n) begin
    n_as++;
    cap_addr = address;
    cap_code = {function_code, transfer_width};
  end
  // Read captures counted from the registered pulse, seen at the edge after it rises
  always @(posedge clock) begin
    if (rd_valid === 1'b1) begin
      n_rd++;
    end
  end

  // ****************
  // Helpers
  // ****************
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_done();
    for (int k = 0; k < 300 && done !== 1'b1; k++) step(1);
    if (done !== 1'b1) begin
      check("done", 32'h1, 32'(done));
      give_verdict();
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_rmw(input logic [1:0] reads, input logic [1:0] writes, input logic [3:0] waits);
    int exp_as;
    exp_as = reads + 1 + ((writes == 2'h3) ? 0 : writes + 1);
    wait_cyc = waits;
    rd_word = 16'h3c00 | 16'(waits);
    rmw_wdata = ~rd_word;
    rmw_reads = reads;
    rmw_writes = writes;
    rmw_addr_step = reads[0];
    use_err = 1'b0;
    bus_request_in_n = 1'b0;
    n_as = 0;
    n_rd = 0;
    rmw_start = 1'b1;
    step(1);
    rmw_start = 1'b0;
    wait_done();
    bus_request_in_n = 1'b1;
    check("cycles", 32'(exp_as), 32'(n_as));
    check("rdata", 32'(rd_word), 32'(rdata));
    check("captures", 32'(reads) + 32'h1, 32'(n_rd));
    check("rmw code", {26'h0, rmw_fc, rmw_width}, {26'h0, cap_code});
    if (writes != 2'h3) check("written", 32'(rmw_wdata), 32'(wr_word));
    step(1);
    check("lock off", 32'h1, 32'(locked_cycle_n));
    check("grant", 32'h0, 32'(bus_grant_out_n));
  endtask
  task automatic t_sw(input logic [2:0] num, input logic p8, input logic err);
    port_8bit = p8;
    use_err = err;
    wait_cyc = 4'h1;
    sw_breakpoint_request_n_num = num;
    rd_word = {5'h1d, num, 8'ha5};
    n_as = 0;
    sw_breakpoint_request_n_start = 1'b1;
    step(1);
    sw_breakpoint_request_n_start = 1'b0;
    wait_done();
    check("sw result", 32'(err ? LRC_BK_ILLEGAL : LRC_BK_OPCODE), 32'(breakpoint_request_n_result));
    check("sw addr", {24'h0, LRC_CPU_TYPE_BREAKPOINT_REQUEST_N, num, 1'b0}, {24'h0, cap_addr[19:16], cap_addr[4:1]});
    check("sw code", {26'h0, LRC_FC_CPU_SPACE, p8 ? LRC_WIDTH_BYTE : LRC_WIDTH_WORD}, {26'h0, cap_code});
    if (!err) check("opcode", 32'(rd_word), 32'(rdata));
    if (!err) check("sw reads", p8 ? 32'h2 : 32'h1, 32'(n_as));
  endtask
  task automatic t_hw(input logic err);
    use_err = err;
    port_8bit = 1'b0;
    n_as = 0;
    breakpoint_request_n = 1'b0;
    step(1);
    breakpoint_request_n = 1'b1;
    wait_done();
    check("hw result", 32'(err ? LRC_BK_HW_EXC : LRC_BK_NONE), 32'(breakpoint_request_n_result));
    check("hw addr", {24'h0, LRC_CPU_TYPE_BREAKPOINT_REQUEST_N, LRC_HW_BREAKPOINT_REQUEST_N_NUM, 1'b1},
      {24'h0, cap_addr[19:16], cap_addr[4:1]});
    check("hw code", {26'h0, LRC_FC_CPU_SPACE, LRC_WIDTH_WORD}, {26'h0, cap_code});
    step(10);
    check("hw once", 32'h1, 32'(n_as));
  endtask
  task automatic t_flush();
    breakpoint_request_n_bg_mode = 1'b1;
    n_as = 0;
    breakpoint_request_n = 1'b0;
    step(1);
    breakpoint_request_n = 1'b1;
    step(4);
    check("pending", 32'h1, 32'(breakpoint_request_n_pending));
    pipe_flush = 1'b1;
    step(1);
    pipe_flush = 1'b0;
    breakpoint_request_n_bg_mode = 1'b0;
    step(20);
    check("flushed", 32'h0, {31'h0, breakpoint_request_n_pending} | 32'(n_as));
  endtask
  task automatic t_reset_mid();
    wait_cyc = 4'h8;
    rmw_start = 1'b1;
    step(1);
    rmw_start = 1'b0;
    step(4);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
    check("idle", 32'hf, {28'h0, address_strobe_n, data_strobe_n, locked_cycle_n, data_oe_n});
  endtask

  initial begin
    {clock, rst, rmw_start, sw_breakpoint_request_n_start, port_8bit, pipe_flush, breakpoint_request_n_bg_mode, use_err} = 8'h40;
    {bus_request_in_n, breakpoint_request_n} = 2'h3;
    {rmw_reads, rmw_writes, rmw_addr_step, sw_breakpoint_request_n_num, wait_cyc} = 12'h0;
    {rmw_addr, rmw_fc, rmw_width, rmw_wdata, rd_word} = {32'h1230, 4'h5, LRC_WIDTH_WORD, 32'h0};
    {n_fail, n_tests, n_as, n_rd} = 0;
    step(20);
    rst = 1'b0;
    step(1);
    check("reset", 32'hf, {28'h0, address_strobe_n, data_strobe_n, locked_cycle_n, data_oe_n});
    t_rmw(2'h0, 2'h0, 4'h0);
    t_rmw(2'h1, 2'h3, 4'h3);
    t_rmw(2'h2, 2'h1, 4'h0);
    for (i = 0; i < 8; i++) t_sw(i[2:0], i[0], i == 5);
    t_hw(1'b0);
    t_hw(1'b1);
    t_flush();
    t_reset_mid();
    t_rmw(2'h0, 2'h3, 4'h1);
    give_verdict();
  end
endmodule

// file: dv/lrc_slave_model.sv
// Memory on the far side of the bus, answering each strobe with an acknowledge, or with a bus error when use_err is set.
// Assumes the bench sets waits, error mode and port width between sequences.
`timescale 1ns/10ps
module lrc_slave_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // From the sequencer
  input wire logic read_not_write,
  input wire logic address_strobe_n,
  input wire logic data_strobe_n,
  input wire logic [15:0] data_out,
  // Behaviour
  input wire logic [3:0] wait_cyc,
  input wire logic use_err,
  input wire logic port8,
  input wire logic [15:0] rd_word,
  // Answers
  output logic [1:0] data_ack_width_n,
  output logic bus_error_n,
  output logic [15:0] data_in,
  output logic [15:0] wr_word
);
  logic [3:0] cnt_q;
  logic hi_q;
  logic [15:0] last_q;
  logic drive;
  // ****************
  // Answer
  // ****************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      hi_q <= 1'b1;
      data_ack_width_n <= 2'h3;
      bus_error_n <= 1'b1;
    end else if (address_strobe_n) begin
      // Released one edge after the strobe negates, so it cannot leak into the next cycle
      if (port8 && !data_ack_width_n[0]) begin
        hi_q <= !hi_q;
      end
      cnt_q <= 4'h0;
      data_ack_width_n <= 2'h3;
      bus_error_n <= 1'b1;
    end else if (cnt_q < wait_cyc) begin
      cnt_q <= cnt_q + 4'h1;
    end else if (read_not_write || !data_strobe_n) begin
      bus_error_n <= !use_err;
      data_ack_width_n <= use_err ? 2'h3 : (port8 ? 2'h2 : 2'h1);
    end
  end
  // Lane choice is simplified: an 8-bit port gives high then low byte on the upper lane
  always_ff @(posedge clock) begin
    if (!read_not_write && !data_strobe_n) begin
      wr_word <= data_out;
    end
    last_q <= data_in;
  end
  // A released bus shows the inverse of its last value, never a stale match
  assign drive = !data_strobe_n && read_not_write && !use_err;
  assign data_in = !drive ? ~last_q : (port8 ? {(hi_q ? rd_word[15:8] : rd_word[7:0]), ~last_q[7:0]} : rd_word);
endmodule
